// File: ibf_status_flags.v
// two-wire bus event flags with AHB-Lite register slave and interrupt
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ibf_map.vh"
module ibf_status_flags (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output wire        irq,
  input  wire        sclIn,
  output wire        sclOut,
  output wire        sclOe,
  input  wire        sdaIn,
  output wire        sdaOut,
  output wire        sdaOe
);
  // pins pass two flops first
  wire [1:0] pinSync;
  ibf_sync #(.WIDTH(2)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .asyncIn ({sclIn, sdaIn}),
    .syncOut (pinSync)
  );
  wire sclS = pinSync[1];
  wire sdaS = pinSync[0];

  reg        sclPrev_reg;
  reg        sdaPrev_reg;
  reg [31:0] hrdata_reg;
  reg        hreadyout_reg;
  reg        irq_reg;
  reg        sclOe_reg;
  reg        sdaOe_reg;
  reg        wrPend_reg;
  reg [7:0]  wrAddr_reg;
  reg        enable_reg;
  reg        soLatch_reg;
  reg        ack_reg;
  reg        start_reg;
  reg        stop_reg;
  reg        trc_reg;
  reg        wait_reg;
  reg        active_reg;
  reg        addrByte_reg;
  reg [3:0]  bitCnt_reg;
  reg [2:0]  intStat_reg;
  reg [2:0]  intEn_reg;

  // bus side decode
  wire       addrValid = hsel & htrans[1] & hready;
  wire       ctrlWr    = wrPend_reg & (wrAddr_reg == `IBF_OFS_CTRL);
  wire       intClrWr  = wrPend_reg & (wrAddr_reg == `IBF_OFS_INT_CLR);
  wire       intEnWr   = wrPend_reg & (wrAddr_reg == `IBF_OFS_INT_EN);
  wire       wrelReq   = ctrlWr & hwdata[`IBF_CTRL_WAIT_REL];
  wire       lrelReq   = ctrlWr & hwdata[`IBF_CTRL_BUS_REL];
  wire       enFall    = ctrlWr & enable_reg & ~hwdata[`IBF_CTRL_ENABLE];
  wire       enNext    = ctrlWr ? hwdata[`IBF_CTRL_ENABLE] : enable_reg;
  wire       soNext    = ctrlWr ? hwdata[`IBF_CTRL_SO_LATCH] : soLatch_reg;

  // line events, only while enabled
  wire startDet  = enable_reg & sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
  wire stopDet   = enable_reg & sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;
  wire sclRise   = enable_reg & active_reg & sclS & ~sclPrev_reg;
  wire sclFall   = enable_reg & active_reg & ~sclS & sclPrev_reg;
  wire firstClk  = sclRise & (bitCnt_reg == 4'h0) & ~wait_reg;
  wire lsbClk    = sclRise & (bitCnt_reg == `IBF_BIT_LSB);
  wire ninthRise = sclRise & (bitCnt_reg == `IBF_BIT_NINTH);
  wire ninthFall = sclFall & (bitCnt_reg == `IBF_BIT_DONE);
  wire ackSet    = ninthRise & ~sdaS;

  // flag next values, set wins over clear
  wire ackClr    = stopDet | firstClk | lrelReq | enFall;
  wire ackNext   = ackSet | (ack_reg & ~ackClr);
  wire startClr  = stopDet | (firstClk & ~addrByte_reg) | lrelReq | enFall;
  wire startNext = startDet | (start_reg & ~startClr);
  wire stopClr   = (firstClk & addrByte_reg) | enFall;
  wire stopNext  = stopDet | (stop_reg & ~stopClr);
  wire trcSet    = lsbClk & addrByte_reg & sdaS;
  wire trcClr    = (wrelReq & wait_reg) | startDet | stopDet | lrelReq | enFall;
  wire trcNext   = trcSet | (trc_reg & ~trcClr);
  wire waitClr   = wrelReq | lrelReq | enFall | stopDet | startDet;
  wire waitNext  = ninthFall | (wait_reg & ~waitClr);

  wire [2:0] intSet  = {ackSet, stopDet, startDet};
  wire [2:0] intClr  = intClrWr ? hwdata[2:0] : 3'h0;
  wire [2:0] intNext = intSet | (intStat_reg & ~intClr);
  wire [2:0] enMask  = intEnWr ? hwdata[2:0] : intEn_reg;

  // status byte, flags only observable
  wire [7:0] statusByte = {4'h0, trc_reg, ack_reg, start_reg, stop_reg};

  reg [31:0] readMux;
  always @* begin
    readMux = 32'h0000_0000;
    case (haddr[7:0])
      `IBF_OFS_CTRL:     readMux = {24'h00_0000, enable_reg, 6'h00, soLatch_reg};
      `IBF_OFS_STATUS:   readMux = {24'h00_0000, statusByte};
      `IBF_OFS_INT_STAT: readMux = {29'h0000_0000, intStat_reg};
      `IBF_OFS_INT_EN:   readMux = {29'h0000_0000, intEn_reg};
      default:           readMux = 32'h0000_0000;
    endcase
  end

  // framing next values, release and stop end the frame
  reg        activeNext;
  reg        addrByteNext;
  reg [3:0]  bitCntNext;
  always @* begin
    activeNext   = active_reg;
    addrByteNext = addrByte_reg;
    bitCntNext   = bitCnt_reg;
    if (stopDet | lrelReq | enFall) begin
      activeNext   = 1'b0;
      addrByteNext = 1'b0;
      bitCntNext   = 4'h0;
    end else if (startDet) begin
      activeNext   = 1'b1;
      addrByteNext = 1'b1;
      bitCntNext   = 4'h0;
    end else if (ninthFall) begin
      addrByteNext = 1'b0;
      bitCntNext   = 4'h0;
    end else if (sclRise & (bitCnt_reg != `IBF_BIT_DONE)) begin
      bitCntNext = bitCnt_reg + 4'h1;
    end
  end

  // slave drives only after the address byte's ninth fall
  wire sdaOeNext = trcNext & ~soNext & ~addrByteNext;

  // constant bus response and pin levels, still from flops
  reg        hresp_reg;
  reg        sclOut_reg;
  reg        sdaOut_reg;

  // edge history idles high like the lines
  always @(posedge sys_clk) begin
    if (rst) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else if (ce) begin
      sclPrev_reg <= sclS;
      sdaPrev_reg <= sdaS;
    end
  end

  // zero wait, always okay
  always @(posedge sys_clk) begin
    if (rst) begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else if (ce) begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end
  end

  // write address held into the data phase
  always @(posedge sys_clk) begin
    if (rst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end else if (ce) begin
      wrPend_reg <= addrValid & hwrite;
      if (addrValid) begin
        wrAddr_reg <= haddr[7:0];
      end
    end
  end

  // read data loaded in the address phase
  always @(posedge sys_clk) begin
    if (rst) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      if (addrValid & ~hwrite) begin
        hrdata_reg <= readMux;
      end
    end
  end

  // control bits, release bits are pulses only
  always @(posedge sys_clk) begin
    if (rst) begin
      enable_reg  <= 1'b0;
      soLatch_reg <= 1'b0;
    end else if (ce) begin
      enable_reg  <= enNext;
      soLatch_reg <= soNext;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else if (ce) begin
      ack_reg <= ackNext;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      start_reg <= 1'b0;
    end else if (ce) begin
      start_reg <= startNext;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      stop_reg <= 1'b0;
    end else if (ce) begin
      stop_reg <= stopNext;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      trc_reg <= 1'b0;
    end else if (ce) begin
      trc_reg <= trcNext;
    end
  end

  // ninth clock wait holds scl low
  always @(posedge sys_clk) begin
    if (rst) begin
      wait_reg  <= 1'b0;
      sclOe_reg <= 1'b0;
    end else if (ce) begin
      wait_reg  <= waitNext;
      sclOe_reg <= waitNext;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      sdaOe_reg <= 1'b0;
    end else if (ce) begin
      sdaOe_reg <= sdaOeNext;
    end
  end

  // open-drain pins only ever pull low
  always @(posedge sys_clk) begin
    if (rst) begin
      sclOut_reg <= 1'b0;
      sdaOut_reg <= 1'b0;
    end else if (ce) begin
      sclOut_reg <= 1'b0;
      sdaOut_reg <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      intStat_reg <= 3'h0;
    end else if (ce) begin
      intStat_reg <= intNext;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      intEn_reg <= `IBF_INT_EN_RESET;
    end else if (ce) begin
      intEn_reg <= enMask;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= |(intNext & enMask);
    end
  end

  // byte framing
  always @(posedge sys_clk) begin
    if (rst) begin
      active_reg   <= 1'b0;
      addrByte_reg <= 1'b0;
      bitCnt_reg   <= 4'h0;
    end else if (ce) begin
      active_reg   <= activeNext;
      addrByte_reg <= addrByteNext;
      bitCnt_reg   <= bitCntNext;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;
  assign irq       = irq_reg;
  assign sclOut    = sclOut_reg;
  assign sclOe     = sclOe_reg;
  assign sdaOut    = sdaOut_reg;
  assign sdaOe     = sdaOe_reg;
endmodule // ibf_status_flags
`default_nettype wire

// File: ibf_map.vh
// register map, field positions and reset values of the bus event flag block
`ifndef IBF_MAP_VH
`define IBF_MAP_VH

`define IBF_OFS_CTRL        8'h00
`define IBF_OFS_STATUS      8'h04
`define IBF_OFS_INT_STAT    8'h08
`define IBF_OFS_INT_CLR     8'h0C
`define IBF_OFS_INT_EN      8'h10

`define IBF_CTRL_SO_LATCH   0
`define IBF_CTRL_WAIT_REL   5
`define IBF_CTRL_BUS_REL    6
`define IBF_CTRL_ENABLE     7

`define IBF_ST_STOP         0
`define IBF_ST_START        1
`define IBF_ST_ACK          2
`define IBF_ST_TRANSMIT     3

`define IBF_INT_START       0
`define IBF_INT_STOP        1
`define IBF_INT_ACK         2

`define IBF_CTRL_RESET      8'h00
`define IBF_INT_EN_RESET    3'h0
`define IBF_BIT_LSB         4'h7
`define IBF_BIT_NINTH       4'h8
`define IBF_BIT_DONE        4'h9

`endif

// File: ibf_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ibf_sync #(
  parameter WIDTH = 1
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire             ce,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  always @(posedge sys_clk) begin
    if (rst) begin
      stage1_reg <= {WIDTH{1'b1}};
      stage2_reg <= {WIDTH{1'b1}};
    end else if (ce) begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;
endmodule // ibf_sync
`default_nettype wire

// File: ibf_chk.sv
// port assertions of the bus event flag block
`timescale 1ns/1ps
`default_nettype none
module ibf_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq,
  input wire logic        sclIn,
  input wire logic        sclOe,
  input wire logic        sdaOut,
  input wire logic        sdaOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] a);
    hsel && htrans[1] && hwrite && hready && haddr[7:0] == a;
  endsequence
  property p_wrel; s_wr(8'h00) ##1 (hwdata[5] && sclOe) |=> ##1 !sclOe && !sdaOe; endproperty
  a_wrel: assert property (p_wrel) else $error("wait release kept pins");
  property p_rel; s_wr(8'h00) ##1 (hwdata[6] || !hwdata[7]) |=> ##1 !sclOe && !sdaOe; endproperty
  a_rel: assert property (p_rel) else $error("release kept pins");
  property p_irq; s_wr(8'h10) ##1 hwdata[2:0] == 3'h0 |=> ##1 !irq; endproperty
  a_irq: assert property (p_irq) else $error("masked irq high");
  property p_rst; disable iff (1'b0) rst |=> !irq && !sclOe && !sdaOe && hrdata == 32'h0000_0000; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_resp; hresp == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("hresp not okay");
  property p_rdy; hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("hreadyout low");
  property p_od; sdaOut == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda drives high");
  property p_sda; $rose(sdaOe) |-> !sclIn; endproperty
  a_sda: assert property (p_sda) else $error("sda moved, scl high");
endmodule // ibf_chk
bind ibf_status_flags ibf_chk chk_u (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .sclIn(sclIn), .sclOe(sclOe),
  .sdaOut(sdaOut), .sdaOe(sdaOe));
`default_nettype wire

// File: ibf_bus_model.sv
// two-wire bus master model with pull-ups
`timescale 1ns/1ps
`default_nettype none
module ibf_bus_model (
  input  wire logic sclOe,
  input  wire logic sdaOe,
  output wire logic scl,
  output wire logic sda
);
  logic mScl = 1'b1;
  logic mSda = 1'b1;
  assign scl = mScl & ~sclOe;
  assign sda = mSda & ~sdaOe;
  task automatic sendBit(input logic b);
    mSda = b;
    #31.25 mScl = 1'b1;
    wait (scl);
    #62.5 mScl = 1'b0;
    #31.25;
  endtask
  task automatic start();
    #62.5 mSda = 1'b0;
    #62.5 mScl = 1'b0;
    #131;
  endtask
  task automatic stop();
    mSda = 1'b0;
    #31.25 mScl = 1'b1;
    wait (scl);
    #62.5 mSda = 1'b1;
    #162.5;
  endtask
  task automatic sendByte(input logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) sendBit(d[i]);
    sendBit(!ack);
    #100;
  endtask
endmodule // ibf_bus_model
`default_nettype wire

// File: tb.sv
// bench for the bus event flag block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [31:0] haddr   = 32'h0000_0000;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0000_0000;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, irq, sclOe, sdaOe, scl, sda;
  integer      n_errors = 0;
  integer      checks   = 0;
  ibf_status_flags dut_u (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .sclIn(scl),
    .sclOut(), .sclOe(sclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe));
  ibf_bus_model m_u (.sclOe(sclOe), .sdaOe(sdaOe), .scl(scl), .sda(sda));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chkPin(input string n, input logic e);
    logic g;
    repeat (2) @(posedge sys_clk);
    #1;
    g = (n == "irq") ? irq : ((n == "sdaOe") ? sdaOe : sclOe);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(n, {24'h00_0000, e}, r);
  endtask
  task automatic end_of_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000 n_errors++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(8'h00, 8'h00, "ctrl");
    rd(8'h04, 8'h00, "status");
    rd(8'h10, 8'h00, "int_en");
    rd(8'h20, 8'h00, "unmapped");
    wr(8'h10, 8'h07);
    wr(8'h00, 8'h80);
    m_u.start();
    rd(8'h04, 8'h02, "status");
    chkPin("irq", 1'b1);
    m_u.sendByte(8'hA1, 1'b1);
    rd(8'h04, 8'h0E, "status");
    chkPin("sdaOe", 1'b1);
    wr(8'h00, 8'hA0);
    chkPin("sdaOe", 1'b0);
    rd(8'h04, 8'h06, "status");
    rd(8'h00, 8'h80, "ctrl");
    m_u.sendByte(8'h55, 1'b1);
    rd(8'h04, 8'h04, "status");
    wr(8'h00, 8'hC0);
    rd(8'h04, 8'h00, "status");
    chkPin("sclOe", 1'b0);
    m_u.stop();
    rd(8'h04, 8'h01, "status");
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h01, "status");
    rd(8'h08, 8'h07, "int_stat");
    wr(8'h10, 8'h00);
    chkPin("irq", 1'b0);
    wr(8'h0C, 8'h07);
    rd(8'h08, 8'h00, "int_stat");
    m_u.start();
    rd(8'h04, 8'h03, "status");
    m_u.sendByte(8'hA0, 1'b1);
    rd(8'h04, 8'h06, "status");
    wr(8'h00, 8'h00);
    rd(8'h04, 8'h00, "status");
    wr(8'h00, 8'h80);
    m_u.stop();
    wr(8'h00, 8'hC0);
    rd(8'h04, 8'h01, "status");
    wr(8'h00, 8'h00);
    rd(8'h04, 8'h00, "status");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
